// [src/pba_regs.vh]
// Constants for the bus target agent: commands, timing, widths
`ifndef PBA_REGS_VH
`define PBA_REGS_VH
// Bus command codes on the lower command lines
`define PBA_CMD_SPECIAL 4'h1
`define PBA_CMD_MEM_RD 4'h6
`define PBA_CMD_MEM_WR 4'h7
`define PBA_CMD_CFG_RD 4'ha
`define PBA_CMD_CFG_WR 4'hb
`define PBA_CMD_DAC 4'hd
// Default decode window of the memory target
`define PBA_BASE_DEF 32'h1000_0000
`define PBA_MASK_DEF 32'hffff_f000
// Byte lane width
`define PBA_LANE_W 8
// Address step per data phase, narrow and wide
`define PBA_STEP32 32'h0000_0004
`define PBA_STEP64 32'h0000_0008
// Burst limit before the target asks the master to stop
`define PBA_BURST_DEF 8'h10
// Target state codes
`define PBA_ST_IDLE 3'h0
`define PBA_ST_WAIT 3'h1
`define PBA_ST_DATA 3'h2
`define PBA_ST_TURN 3'h3
`define PBA_ST_SKIP 3'h4
`endif

// [src/pba_sync.v]
// Three-stage input synchroniser with agreement filter
module pba_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire [W-1:0] raw_in,
  output reg [W-1:0] clean_out
);
  reg [W-1:0] st1; // First stage, read only by st2
  reg [W-1:0] st2; // Second stage
  reg [W-1:0] st3; // Third stage
  // Shift chain; accept a change once stages two and three agree
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      st1 <= INIT;
      st2 <= INIT;
      st3 <= INIT;
      clean_out <= INIT;
    end else begin
      st1 <= raw_in;
      st2 <= st1;
      st3 <= st2;
      if (st2 == st3) begin
        clean_out <= st3;
      end
    end
  end
endmodule // pba_sync

// [src/pba_target.v]
// Bus target agent: decode, handshakes, parity, 64-bit, interrupt pin
// Functional notes
// - Address phase then one or more data phases
// - Low lane is byte 0, top lane byte 3
// - Command in address phase, then byte enables
// - Byte enables valid for whole data phase
// - Decoding target drives device select
// - 64-bit acknowledge timed as device select
// - Upper lines: high address, or extra data
// - Upper enables: DAC command, or bytes 4-7
// - Even parity over lower lines and enables
// - Master drives address/write parity, target read
// - Upper parity covers upper lines and enables
// - Report data parity errors except special cycles; upper parity is still checked in them
// - Masters use dedicated request and grant
// - Init select is chip select for configuration
// - Interrupt level, active low, open drain
// - Single function uses line A only
// - Lock still allows unlocked addresses through
// - Everything timed by common bus clock
// - Target ready means data valid or acceptable
// - Target asserts stop to end transaction
// - Reset returns all state to initial
`include "pba_regs.vh"
module pba_target #(
  parameter [31:0] BASE = `PBA_BASE_DEF,
  parameter [31:0] MASK = `PBA_MASK_DEF,
  parameter [7:0] BURST = `PBA_BURST_DEF,
  parameter ENABLE_64 = 1
) (
  input wire clk_in, // Common bus clock
  input wire sys_rst_in, // Synchronous, active high
  input wire [63:0] ad_in, // Shared address/data lines
  output reg [63:0] ad_out,
  output reg ad_oe_out, // Lower 32 lines driven
  output reg ad_hi_oe_out, // Upper 32 lines driven
  input wire [7:0] cbe_n_in, // Command / byte enables, low active
  input wire frame_n_in,
  input wire irdy_n_in,
  input wire idsel_in,
  input wire req64_n_in,
  input wire lock_n_in,
  output reg trdy_n_out,
  output reg devsel_n_out,
  output reg stop_n_out,
  output reg ack64_n_out,
  output reg ctl_oe_out, // Enable for trdy, devsel, stop, ack64
  output reg par_out,
  output reg par_oe_out,
  output reg par64_out,
  output reg par64_oe_out,
  input wire par_in,
  input wire par64_in,
  output reg perr_n_out,
  output reg perr_oe_out,
  input wire inta_req_in, // Function interrupt request, active high
  output reg inta_n_out, // Open-drain value, always low
  output reg inta_oe_out, // High while pulling the line low
  input wire [31:0] rd_data_lo_in, // User read data, low dword
  input wire [31:0] rd_data_hi_in, // User read data, high dword
  input wire rd_ready_in, // User can provide read data now
  input wire wr_ready_in, // User can accept write data now
  output reg [63:0] wr_data_out, // Captured write data
  output reg [7:0] wr_be_out, // Captured byte enables, high active
  output reg wr_valid_out, // Write word pulse
  output reg [31:0] addr_out, // Current word address
  output reg is_cfg_out, // Current access is configuration
  output wire rd_take_out, // Read word consumed pulse
  output reg perr_seen_out // Sticky data parity error flag
);
  // Bus inputs are on the bus clock, so they are used directly
  reg [2:0] state; // Target sequencer state
  reg [2:0] next_state;
  reg frame_q; // Frame seen last cycle (active high)
  reg [31:0] addr; // Running address
  reg [3:0] cmd; // Latched command
  reg wide; // 64-bit transfer accepted
  reg dac_hi; // Second address phase of dual cycle pending
  reg [7:0] beats; // Data phases done in burst
  reg locked; // This target is locked by a master
  reg [31:0] lock_addr; // Locked address
  reg par_chk; // Check parity on next edge
  reg par64_chk;
  reg [35:0] chk_lo; // Lines captured for parity check
  reg [35:0] chk_hi;
  wire frame = ~frame_n_in;
  wire irdy = ~irdy_n_in;
  wire start = frame & ~frame_q; // Address phase
  wire [3:0] acmd = cbe_n_in[3:0];
  wire is_rd = (acmd == `PBA_CMD_MEM_RD) | (acmd == `PBA_CMD_CFG_RD);
  wire is_wr = (acmd == `PBA_CMD_MEM_WR) | (acmd == `PBA_CMD_CFG_WR);
  wire is_cfg = (acmd == `PBA_CMD_CFG_RD) | (acmd == `PBA_CMD_CFG_WR);
  // Config selected by init select, memory by window
  wire hit_mem = ((ad_in[31:0] & MASK) == BASE) & ~is_cfg;
  wire hit = (is_rd | is_wr) & (is_cfg ? idsel_in : hit_mem);
  // Locked address refused only to non-lock masters
  wire lock_block = locked & lock_n_in & (ad_in[31:0] == lock_addr);
  wire dac = (acmd == `PBA_CMD_DAC);
  wire rd = (cmd == `PBA_CMD_MEM_RD) | (cmd == `PBA_CMD_CFG_RD);
  wire user_rdy = rd ? rd_ready_in : wr_ready_in;
  wire xfer = (state == `PBA_ST_DATA) & irdy & ~trdy_n_out;
  wire last = ~frame; // Final data phase when frame gone
  assign rd_take_out = xfer & rd;
  // Even parity helper: xor of bits gives even count
  function par36;
    input [35:0] v;
    begin
      par36 = ^v;
    end
  endfunction
  // Sequencer next state
  always @* begin
    next_state = state;
    case (state)
      `PBA_ST_IDLE: begin
        if (start & dac) begin
          next_state = `PBA_ST_WAIT; // High address follows
        end else if (start & hit & ~lock_block) begin
          next_state = `PBA_ST_DATA;
        end else if (start) begin
          next_state = `PBA_ST_SKIP;
        end
      end
      `PBA_ST_WAIT: begin
        next_state = (hit & ~lock_block) ? `PBA_ST_DATA : `PBA_ST_SKIP;
      end
      `PBA_ST_DATA: begin
        if ((xfer | ~stop_n_out) & last & irdy) begin
          next_state = `PBA_ST_TURN;
        end
      end
      `PBA_ST_TURN: begin
        next_state = `PBA_ST_IDLE;
      end
      `PBA_ST_SKIP: begin
        if (~frame & ~irdy) begin
          next_state = `PBA_ST_IDLE;
        end
      end
      default: begin
        next_state = `PBA_ST_IDLE;
      end
    endcase
  end
  // Sequencer, handshakes and data path, all on rising edge
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= `PBA_ST_IDLE;
      frame_q <= 1'b0;
      addr <= 32'h0000_0000;
      cmd <= 4'h0;
      wide <= 1'b0;
      dac_hi <= 1'b0;
      beats <= 8'h00;
      ad_out <= 64'h0;
      ad_oe_out <= 1'b0;
      ad_hi_oe_out <= 1'b0;
      trdy_n_out <= 1'b1;
      devsel_n_out <= 1'b1;
      stop_n_out <= 1'b1;
      ack64_n_out <= 1'b1;
      ctl_oe_out <= 1'b0;
      wr_data_out <= 64'h0;
      wr_be_out <= 8'h00;
      wr_valid_out <= 1'b0;
      addr_out <= 32'h0000_0000;
      is_cfg_out <= 1'b0;
      locked <= 1'b0;
      lock_addr <= 32'h0000_0000;
    end else begin
      state <= next_state;
      frame_q <= frame;
      wr_valid_out <= 1'b0;
      if (state == `PBA_ST_IDLE & start) begin
        addr <= ad_in[31:0];
        cmd <= acmd;
        dac_hi <= dac;
        beats <= 8'h00;
        // Master asks for 64 bits with frame
        wide <= (ENABLE_64 != 0) & ~req64_n_in;
      end
      if (state == `PBA_ST_WAIT) begin
        // Second address phase gives the address and command that are decoded
        addr <= ad_in[31:0];
        cmd <= cbe_n_in[3:0];
      end
      // Claim the access: select and 64-bit ack together
      if (next_state == `PBA_ST_DATA & state != `PBA_ST_DATA) begin
        devsel_n_out <= 1'b0;
        ack64_n_out <= ~wide_next(state, req64_n_in, wide);
        ctl_oe_out <= 1'b1; // Drive only once claimed
        addr_out <= (state == `PBA_ST_WAIT) ? ad_in[31:0] : ad_in[31:0];
        is_cfg_out <= is_cfg;
        // Lock is taken by first locked access
        if (~lock_n_in & ~locked) begin
          locked <= 1'b1;
          lock_addr <= ad_in[31:0];
        end
      end
      if (state == `PBA_ST_DATA) begin
        // Ready only with data valid or room to take it
        trdy_n_out <= ~(user_rdy & ~(xfer & last));
        // Ask master to stop at burst limit
        if (xfer & (beats == BURST - 8'h01) & ~last) begin
          stop_n_out <= 1'b0;
          trdy_n_out <= 1'b1;
        end
        if (rd) begin // Target drives read data and lanes
          ad_out <= {rd_data_hi_in, rd_data_lo_in};
          ad_oe_out <= 1'b1;
          ad_hi_oe_out <= wide; // Extra dword only when both
        end
        if (xfer) begin
          beats <= beats + 8'h01;
          addr <= addr + (wide ? `PBA_STEP64 : `PBA_STEP32);
          addr_out <= addr + (wide ? `PBA_STEP64 : `PBA_STEP32);
          if (~rd) begin
            wr_data_out <= wide ? ad_in : {32'h0, ad_in[31:0]};
            // Enables sampled within the phase
            wr_be_out <= wide ? ~cbe_n_in : {4'h0, ~cbe_n_in[3:0]};
            wr_valid_out <= 1'b1;
          end
        end
      end
      if (next_state == `PBA_ST_TURN) begin
        trdy_n_out <= 1'b1;
        devsel_n_out <= 1'b1;
        ack64_n_out <= 1'b1;
        stop_n_out <= 1'b1;
        ad_oe_out <= 1'b0;
        ad_hi_oe_out <= 1'b0;
      end
      if (state == `PBA_ST_TURN) begin
        ctl_oe_out <= 1'b0; // Outputs released after turnaround
      end
      if (lock_n_in & frame_n_in) begin
        locked <= 1'b0; // Lock released when idle and lock drops
      end
    end
  end
  // Acknowledge 64 bits only when master asked at frame
  function wide_next;
    input [2:0] st;
    input req_n;
    input w;
    begin
      wide_next = (st == `PBA_ST_IDLE) ? ((ENABLE_64 != 0) & ~req_n) : w;
    end
  endfunction
  // Read parity one clock after data, driven by target
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      par_out <= 1'b0;
      par_oe_out <= 1'b0;
      par64_out <= 1'b0;
      par64_oe_out <= 1'b0;
    end else begin
      par_out <= par36({cbe_n_in[3:0], ad_out[31:0]});
      par64_out <= par36({cbe_n_in[7:4], ad_out[63:32]});
      par_oe_out <= ad_oe_out;
      par64_oe_out <= ad_hi_oe_out;
    end
  end
  // Write parity check: capture lines, compare next clock
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      par_chk <= 1'b0;
      par64_chk <= 1'b0;
      chk_lo <= 36'h0;
      chk_hi <= 36'h0;
      perr_n_out <= 1'b1;
      perr_oe_out <= 1'b0;
      perr_seen_out <= 1'b0;
    end else begin
      par_chk <= xfer & ~rd & (cmd != `PBA_CMD_SPECIAL);
      par64_chk <= xfer & ~rd & wide;
      chk_lo <= {cbe_n_in[3:0], ad_in[31:0]};
      chk_hi <= {cbe_n_in[7:4], ad_in[63:32]};
      // Report errors of checked phases one clock after their parity arrives
      if ((par_chk & (par36(chk_lo) != par_in)) |
          (par64_chk & (par36(chk_hi) != par64_in))) begin
        perr_n_out <= 1'b0;
        perr_oe_out <= 1'b1;
        perr_seen_out <= 1'b1;
      end else begin
        perr_n_out <= 1'b1;
        perr_oe_out <= ~perr_n_out; // Drive high one clock, then release
      end
    end
  end
  // Request may come from another clock domain: three-stage filter
  wire inta_req; // Synchronised interrupt request
  pba_sync #(
    .W(1),
    .INIT(1'b0)
  ) i_inta_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .raw_in(inta_req_in),
    .clean_out(inta_req)
  );
  // Single function: line A only, open drain, level
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      inta_n_out <= 1'b0;
      inta_oe_out <= 1'b0;
    end else begin
      inta_n_out <= 1'b0;
      inta_oe_out <= inta_req;
    end
  end
endmodule // pba_target

// [test/pba_master_model.sv]
// Bus master model: frames, enables, parity and ready toward the target
module pba_master_model (
  input wire logic clk_in,
  input wire logic [63:0] ad_in,
  input wire logic trdy_n_in,
  input wire logic devsel_n_in,
  input wire logic stop_n_in,
  input wire logic ack64_n_in,
  output logic [63:0] ad_out,
  output logic ad_oe_out,
  output logic [7:0] cbe_n_out,
  output logic frame_n_out,
  output logic irdy_n_out,
  output logic par_out,
  output logic par64_out,
  output logic req64_n_out,
  output logic idsel_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bad; // Spoils write parity on purpose
  logic hit; // Device select seen
  logic ack; // Wide acknowledge seen
  logic [63:0] rdat; // Word taken at the last handshake
  initial begin
    {frame_n_out, irdy_n_out, req64_n_out, cbe_n_out} = 11'h7ff;
    {ad_oe_out, idsel_out, bad, hit, ack} = 5'h0;
    ad_out = 64'h0;
  end
  // Parity follows its phase by one clock
  always @(posedge clk_in) begin
    par_out <= ^{ad_in[31:0], cbe_n_out[3:0]} ^ bad;
    par64_out <= ^{ad_in[63:32], cbe_n_out[7:4]};
  end
  // Address phase, then n data phases of d+k
  task xfer(input [3:0] cmd, input [31:0] a, input [63:0] d,
            input [7:0] be, input int n, input logic w64, sp, sel);
    int k;
    int t;
    @(negedge clk_in);
    {hit, ack, idsel_out} = {2'h0, sel};
    frame_n_out = 1'h0;
    req64_n_out = ~w64;
    ad_oe_out = 1'h1;
    ad_out = {32'h0, a};
    cbe_n_out = {4'h0, cmd};
    for (k = 0; k < n; k++) begin
      @(negedge clk_in);
      ad_oe_out = cmd[0]; // Writes keep the lines
      ad_out = d + k;
      cbe_n_out = ~be;
      irdy_n_out = 1'h0;
      frame_n_out = (k == n - 1); // Final phase
      bad = sp;
      // Wait for the target, or give up as a master abort
      for (t = 0; t < 8; t++) begin
        @(posedge clk_in);
        hit |= !devsel_n_in;
        ack |= !ack64_n_in;
        if (!trdy_n_in || !stop_n_in)
          break;
      end
      rdat = ad_in;
      if (trdy_n_in || !stop_n_in)
        break;
    end
    @(negedge clk_in);
    if (!frame_n_out) begin
      frame_n_out = 1'h1;
      @(negedge clk_in);
    end
    {irdy_n_out, req64_n_out, ad_oe_out, bad} = 4'hc;
    ad_out = ~ad_out; // Released lines show the last driven value
    cbe_n_out = ~cbe_n_out;
    @(negedge clk_in);
  endtask
endmodule // pba_master_model

// [test/pba_target_checker.sv]
// Checker of the bus target agent, bound onto its ports
module pba_target_checker (
  input wire clk_in,
  input wire sys_rst_in,
  input wire [63:0] ad_in,
  input wire [63:0] ad_out,
  input wire [7:0] cbe_n_in,
  input wire frame_n_in,
  input wire irdy_n_in,
  input wire trdy_n_out,
  input wire devsel_n_out,
  input wire ack64_n_out,
  input wire par_out,
  input wire par_oe_out,
  input wire par64_out,
  input wire par64_oe_out,
  input wire perr_n_out,
  input wire perr_oe_out,
  input wire [63:0] wr_data_out,
  input wire [7:0] wr_be_out,
  input wire wr_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_ack_devsel:
    assert property (!ack64_n_out |-> !devsel_n_out &&
      $past(ack64_n_out) == $past(devsel_n_out)) else $error("ack64 skew");
  a_claim_frame:
    assert property ($fell(devsel_n_out) |-> !$past(frame_n_in))
    else $error("devsel without frame");
  a_trdy_claim:
    assert property (!trdy_n_out |-> !devsel_n_out)
    else $error("trdy without devsel");
  a_par_low:
    assert property (par_oe_out |-> par_out ==
      ^{$past(ad_out[31:0]), $past(cbe_n_in[3:0])}) else $error("par");
  a_par_high:
    assert property (par64_oe_out |-> par64_out ==
      ^{$past(ad_out[63:32]), $past(cbe_n_in[7:4])}) else $error("par64");
  a_perr_shape:
    assert property (!perr_n_out |-> perr_oe_out ##1 perr_n_out &&
      perr_oe_out) else $error("perr pulse");
  a_write_hs:
    assert property (wr_valid_out |-> $past(!trdy_n_out && !irdy_n_in))
    else $error("write without handshake");
  a_write_lanes:
    assert property (wr_valid_out |-> wr_be_out[3:0] == ~$past(cbe_n_in[3:0])
      && wr_data_out[31:0] == $past(ad_in[31:0])) else $error("lanes");
  c_write: cover property (wr_valid_out);
  c_wide: cover property (!ack64_n_out);
  c_perr: cover property (!perr_n_out);
endmodule // pba_target_checker
bind pba_target pba_target_checker i_chk (.clk_in, .sys_rst_in, .ad_in,
  .ad_out, .cbe_n_in, .frame_n_in, .irdy_n_in, .trdy_n_out, .devsel_n_out,
  .ack64_n_out, .par_out, .par_oe_out, .par64_out, .par64_oe_out,
  .perr_n_out, .perr_oe_out, .wr_data_out, .wr_be_out, .wr_valid_out);

// [test/pci_bus_agent_signalling_bench.sv]
// Self-checking bench for the bus target agent
`include "pba_regs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  num_errors++; $display("ERROR %0t mismatch", $time); end end
module pci_bus_agent_signalling_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] B = `PBA_BASE_DEF;
  logic clk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic inta_req_in = 1'h0;
  logic lock_n = 1'h1; // Lock line, active low
  logic [63:0] bus, m_ad, ad_out, wr_data_out, wd;
  logic [7:0] cbe, wr_be_out, wb;
  logic m_oe, fr, ir, sel, r64, mp, mp64, ad_oe_out, ad_hi_oe_out;
  logic trdy_n_out, devsel_n_out, stop_n_out, ack64_n_out, par_out;
  logic par_oe_out, par64_out, par64_oe_out, perr_n_out, perr_oe_out;
  logic inta_n_out, inta_oe_out, wr_valid_out, is_cfg_out, perr_seen_out;
  logic [31:0] addr_out;
  int num_errors = 0, n_compared = 0, cyc = 0, wn = 0;
  // Lines left undriven show the inverse of the model's last value
  assign bus[31:0] = m_oe ? m_ad[31:0] : ad_oe_out ? ad_out[31:0] : ~m_ad[31:0];
  assign bus[63:32] = m_oe ? m_ad[63:32] :
    ad_hi_oe_out ? ad_out[63:32] : ~m_ad[63:32];
  always #2.5 clk_in = ~clk_in;
  pba_target i_dut (.clk_in, .sys_rst_in, .ad_in(bus), .ad_out, .ad_oe_out,
    .ad_hi_oe_out, .cbe_n_in(cbe), .frame_n_in(fr), .irdy_n_in(ir),
    .idsel_in(sel), .req64_n_in(r64), .lock_n_in(lock_n), .trdy_n_out,
    .devsel_n_out, .stop_n_out, .ack64_n_out, .ctl_oe_out(), .par_out,
    .par_oe_out, .par64_out, .par64_oe_out, .par_in(mp), .par64_in(mp64),
    .perr_n_out, .perr_oe_out, .inta_req_in, .inta_n_out, .inta_oe_out,
    .rd_data_lo_in(32'h1234_5678), .rd_data_hi_in(32'h9abc_def0),
    .rd_ready_in(1'h1), .wr_ready_in(1'h1), .wr_data_out, .wr_be_out,
    .wr_valid_out, .addr_out, .is_cfg_out, .rd_take_out(), .perr_seen_out);
  pba_master_model i_mst (.clk_in, .ad_in(bus), .trdy_n_in(trdy_n_out),
    .devsel_n_in(devsel_n_out), .stop_n_in(stop_n_out),
    .ack64_n_in(ack64_n_out), .ad_out(m_ad), .ad_oe_out(m_oe),
    .cbe_n_out(cbe), .frame_n_out(fr), .irdy_n_out(ir), .par_out(mp),
    .par64_out(mp64), .req64_n_out(r64), .idsel_out(sel));
  // Capture of each written word mid-cycle, where it has settled; watchdog
  always @(negedge clk_in) begin
    cyc++;
    if (wr_valid_out === 1'h1) begin
      wn++;
      wd = wr_data_out;
      wb = wr_be_out;
    end
    if (cyc == 2000) begin
      num_errors++;
      finish_test;
    end
  end
  task t_reset;
    `CHK({trdy_n_out, devsel_n_out, stop_n_out, ack64_n_out}, 4'hf)
    `CHK({perr_n_out, par_oe_out, ad_oe_out, inta_oe_out}, 4'h8)
  endtask
  task t_write;
    i_mst.xfer(`PBA_CMD_MEM_WR, B + 32'h8, 64'hc3a5_5a3c, 8'h05, 1, 0, 0, 0);
    `CHK(wn, 1)
    `CHK(wd[31:0], 32'hc3a5_5a3c)
    `CHK(wb[3:0], 4'h5)
    `CHK({addr_out, is_cfg_out}, {B + 32'hc, 1'h0})
    i_mst.xfer(`PBA_CMD_MEM_WR, B, 64'h0bad_f00d_0000_0001, 8'hff, 2, 1, 0, 0);
    `CHK(i_mst.ack, 1'h1)
    `CHK({wn, wd}, {32'h3, 64'h0bad_f00d_0000_0002})
    `CHK(wb, 8'hff)
  endtask
  task t_read;
    i_mst.xfer(`PBA_CMD_MEM_RD, B, 64'h0, 8'h0f, 1, 0, 0, 0);
    `CHK(i_mst.rdat[31:0], 32'h1234_5678)
    i_mst.xfer(`PBA_CMD_MEM_RD, B, 64'h0, 8'hff, 1, 1, 0, 0);
    `CHK(i_mst.rdat, 64'h9abc_def0_1234_5678)
  endtask
  task t_decode;
    i_mst.xfer(`PBA_CMD_MEM_WR, 32'h2000_0000, 64'h1, 8'h0f, 1, 0, 0, 0);
    `CHK({i_mst.hit, wn}, {1'h0, 32'h3})
    i_mst.xfer(`PBA_CMD_CFG_WR, 32'h4, 64'h77, 8'h0f, 1, 0, 0, 0);
    `CHK(i_mst.hit, 1'h0)
    i_mst.xfer(`PBA_CMD_CFG_WR, 32'h4, 64'h77, 8'h0f, 1, 0, 0, 1);
    `CHK({i_mst.hit, wn, wd[31:0]}, {1'h1, 32'h4, 32'h77})
    `CHK(is_cfg_out, 1'h1)
  endtask
  task t_burst;
    int w0;
    w0 = wn;
    i_mst.xfer(`PBA_CMD_MEM_WR, B + 32'h40, 64'h100, 8'hff, 17, 0, 0, 0);
    `CHK(wn - w0, 16)
    `CHK({wd[31:0], stop_n_out}, {32'h10f, 1'h1})
  endtask
  task t_lock;
    int w0;
    w0 = wn;
    lock_n = 1'h0;
    i_mst.xfer(`PBA_CMD_MEM_WR, B + 32'h80, 64'h11, 8'h0f, 1, 0, 0, 0);
    i_mst.xfer(`PBA_CMD_MEM_WR, B + 32'h84, 64'h22, 8'h0f, 1, 0, 0, 0);
    `CHK({i_mst.hit, wn - w0}, {1'h1, 32'h2})
    fork
      i_mst.xfer(`PBA_CMD_MEM_WR, B + 32'h80, 64'h33, 8'h0f, 1, 0, 0, 0);
      begin
        @(negedge clk_in);
        lock_n = 1'h1;
      end
    join
    `CHK({i_mst.hit, wn - w0}, {1'h0, 32'h2})
    i_mst.xfer(`PBA_CMD_MEM_WR, B + 32'h80, 64'h44, 8'h0f, 1, 0, 0, 0);
    `CHK({i_mst.hit, wn - w0, wd[31:0]}, {1'h1, 32'h3, 32'h44})
  endtask
  task t_parity;
    i_mst.xfer(`PBA_CMD_SPECIAL, 32'h0, 64'h5, 8'h0f, 1, 0, 1, 0);
    repeat (3) @(negedge clk_in);
    `CHK(perr_seen_out, 1'h0)
    i_mst.xfer(`PBA_CMD_MEM_WR, B, 64'h5, 8'h0f, 1, 0, 1, 0);
    repeat (3) @(negedge clk_in);
    `CHK(perr_seen_out, 1'h1)
  endtask
  task t_irq;
    inta_req_in = 1'h1;
    repeat (6) @(negedge clk_in);
    `CHK({inta_oe_out, inta_n_out}, 2'h2)
    inta_req_in = 1'h0;
    repeat (6) @(negedge clk_in);
    `CHK(inta_oe_out, 1'h0)
  endtask
  task finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_in);
    sys_rst_in = 1'h0;
    t_reset;
    t_write;
    t_read;
    t_decode;
    t_parity;
    t_burst;
    t_lock;
    t_irq;
    finish_test;
  end
endmodule // pci_bus_agent_signalling_bench
